// File: src/ambient_light_measure_ctrl.sv
// Measurement sequencer, serial slave and alert of the light sensor
`timescale 1ns/100ps
`default_nettype none

module ambient_light_measure_ctrl
#(
  parameter int INTEG_SHORT_CYC =
    ambient_light_pkg::INTEG_SHORT_MS * ambient_light_pkg::CYC_PER_MS,
  parameter int INTEG_LONG_CYC =
    ambient_light_pkg::INTEG_LONG_MS * ambient_light_pkg::CYC_PER_MS,
  parameter int ASSESS_CYC =
    ambient_light_pkg::ASSESS_MS * ambient_light_pkg::CYC_PER_MS,
  parameter int OVERHEAD_CYC =
    ambient_light_pkg::OVERHEAD_MS * ambient_light_pkg::CYC_PER_MS,
  parameter int TIMEOUT_CYC =
    ambient_light_pkg::BUS_TIMEOUT_MS * ambient_light_pkg::CYC_PER_MS
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_strap,
  input wire logic [ambient_light_pkg::RAW_W-1:0] raw_light,
  input wire ambient_light_pkg::cfg_t cfg,
  output ambient_light_pkg::status_t status,
  output logic alert_out,
  output logic alert_oe
);
  import ambient_light_pkg::*;

  // ---------------------------------------------------------------
  // State of the measurement (clk) domain
  // ---------------------------------------------------------------
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic [TO_W-1:0] to_cnt;
    logic to_act;
    seq_st_t st;
    logic [CNT_W-1:0] cnt;
    logic [1:0] mode_p;
    logic single;
    logic [5:0] hold;
    logic link_go;
    logic [3:0] exp;
    logic [15:0] pend;
    logic [3:0] pend_best;
    logic [15:0] res;
    logic res_valid;
    logic tgl;
    logic alert_act;
    logic alert_oe;
  } core_t;

  // ---------------------------------------------------------------
  // State of the link (link_clk) domain
  // ---------------------------------------------------------------
  typedef struct packed {
    logic scl_m, scl_s, scl_p;
    logic sda_m, sda_s, sda_p;
    logic strap_m, strap_s, strap_p;
    logic to_m, to_s;
    logic tg_m, tg_s, tg_p;
    logic [15:0] result;
    logic [15:0] rd_word;
    bus_st_t st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic rw;
    logic nack;
    logic lo_byte;
    logic strap_wait;
    logic s0, s1;
    logic [1:0] strap_code;
    logic oe;
  } link_t;

  core_t c_q, c_d;
  link_t l_q, l_d;
  logic lrst_m, lrst_s;
  logic [15:0] scaled;
  logic [3:0] best_exp;
  logic [3:0] exp_sel;
  logic start_cmd;

  // Lux value of a result word, so limits compare across ranges
  function automatic logic [LUX_W-1:0] lux_of(input logic [15:0] w);
    lux_of = LUX_W'(w[MANT_W-1:0]) << w[15:12];
  endfunction : lux_of

  // Fixed range clamps to the largest legal exponent
  // automatic range select
  assign exp_sel = (cfg.full_scale_range_field == RANGE_AUTO) ? c_q.exp :
    ((cfg.full_scale_range_field > EXP_MAX) ? EXP_MAX :
     cfg.full_scale_range_field);

  lux_scale u_scale (
    .raw(raw_light),
    .exp_sel(exp_sel),
    .result(scaled),
    .best_exp(best_exp)
  );

  // Single shot triggers only on entry to its code, not while held
  // continuous or single
  assign start_cmd = (cfg.conv_mode[1] == 1'b1) ||
    ((cfg.conv_mode == MODE_SINGLE) && (c_q.mode_p != MODE_SINGLE));

  // ---------------------------------------------------------------
  // Measurement sequencer and bus timeout watch
  // ---------------------------------------------------------------
  always_comb
  begin
    c_d = c_q;
    c_d.scl_m = scl_in;
    c_d.scl_s = c_q.scl_m;
    c_d.mode_p = cfg.conv_mode;
    // Link side stays in reset 64 edges after release; a short pulse
    // could otherwise fall between two edges of the slower link clock
    if (c_q.hold != 6'h3f)
      c_d.hold = c_q.hold + 6'h1;
    c_d.link_go = (c_q.hold == 6'h3f);
    if (c_q.scl_s)
    begin
      c_d.to_cnt = '0;
      c_d.to_act = 1'b0;
    end
    else if (c_q.to_cnt == TO_W'(TIMEOUT_CYC - 1))
      c_d.to_act = 1'b1;
    else
      c_d.to_cnt = c_q.to_cnt + TO_W'(1);
    case (c_q.st)
      SEQ_SHUT:
      begin
        if (start_cmd)
        begin
          c_d.single = (cfg.conv_mode == MODE_SINGLE);
          if (cfg.full_scale_range_field == RANGE_AUTO)
          begin
            c_d.st = SEQ_ASSESS;
            c_d.cnt = CNT_W'(ASSESS_CYC - 1);
          end
          else
          begin
            c_d.st = SEQ_INTEG;
            c_d.cnt = cfg.integration_length_bit ?
              CNT_W'(INTEG_LONG_CYC - 1) : CNT_W'(INTEG_SHORT_CYC - 1);
          end
        end
      end
      SEQ_ASSESS:
      begin
        if (c_q.cnt == '0)
        begin
          c_d.exp = best_exp;
          c_d.st = SEQ_INTEG;
          c_d.cnt = cfg.integration_length_bit ?
            CNT_W'(INTEG_LONG_CYC - 1) : CNT_W'(INTEG_SHORT_CYC - 1);
        end
        else
          c_d.cnt = c_q.cnt - CNT_W'(1);
      end
      SEQ_INTEG:
      begin
        if (c_q.cnt == '0)
        begin
          c_d.pend = scaled;
          c_d.pend_best = best_exp;
          c_d.st = SEQ_FINISH;
          c_d.cnt = CNT_W'(OVERHEAD_CYC - 1);
        end
        else
          c_d.cnt = c_q.cnt - CNT_W'(1);
      end
      SEQ_FINISH:
      begin
        if (c_q.cnt == '0)
        begin
          c_d.res = c_q.pend;
          c_d.res_valid = 1'b1;
          c_d.tgl = ~c_q.tgl;
          c_d.alert_act = (lux_of(c_q.pend) > lux_of(cfg.high_limit)) ||
            (lux_of(c_q.pend) < lux_of(cfg.low_limit));
          c_d.exp = c_q.pend_best;
          if (c_q.single)
            c_d.st = SEQ_SHUT;
          else
          begin
            c_d.st = SEQ_INTEG;
            c_d.cnt = cfg.integration_length_bit ?
              CNT_W'(INTEG_LONG_CYC - 1) : CNT_W'(INTEG_SHORT_CYC - 1);
          end
        end
        else
          c_d.cnt = c_q.cnt - CNT_W'(1);
      end
      default: c_d.st = SEQ_SHUT;
    endcase
    if (cfg.conv_mode == MODE_SHUTDOWN)
      c_d.st = SEQ_SHUT;
    c_d.alert_oe = c_d.alert_act ^ cfg.alert_sense_invert;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      c_q <= '0;
    else
      c_q <= c_d;
  end

  // ---------------------------------------------------------------
  // Link-side reset, stretched in the clk domain, then synchronised
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk)
  begin
    lrst_m <= ~c_q.link_go;
    lrst_s <= lrst_m;
  end

  // ---------------------------------------------------------------
  // Serial slave, oversampling the bus pins on link_clk
  // ---------------------------------------------------------------
  always_comb
  begin
    l_d = l_q;
    l_d.scl_m = scl_in;
    l_d.scl_s = l_q.scl_m;
    l_d.scl_p = l_q.scl_s;
    l_d.sda_m = sda_in;
    l_d.sda_s = l_q.sda_m;
    l_d.sda_p = l_q.sda_s;
    l_d.strap_m = addr_strap;
    l_d.strap_s = l_q.strap_m;
    l_d.strap_p = l_q.strap_s;
    l_d.to_m = c_q.to_act;
    l_d.to_s = l_q.to_m;
    l_d.tg_m = c_q.tgl;
    l_d.tg_s = l_q.tg_m;
    l_d.tg_p = l_q.tg_s;
    // Result word is held for milliseconds after each toggle
    if (l_q.tg_s != l_q.tg_p)
      l_d.result = c_q.res;
    if (l_q.scl_s && l_q.scl_p && l_q.sda_p && !l_q.sda_s)
    begin
      // Start: strap seen before and after the data line fell
      l_d.st = BUS_ADDR;
      l_d.bits = '0;
      l_d.oe = 1'b0;
      l_d.s0 = l_q.strap_p;
      l_d.s1 = l_q.strap_s;
      l_d.strap_wait = 1'b1;
    end
    else if (l_q.scl_s && l_q.scl_p && !l_q.sda_p && l_q.sda_s)
    begin
      l_d.st = BUS_IDLE;
      l_d.oe = 1'b0;
    end
    else if (!l_q.scl_p && l_q.scl_s)
    begin
      if ((l_q.st == BUS_ADDR) || (l_q.st == BUS_WR))
      begin
        l_d.sh = {l_q.sh[6:0], l_q.sda_s};
        l_d.bits = l_q.bits + 4'h1;
      end
      else if (l_q.st == BUS_RD_ACK)
        l_d.nack = l_q.sda_s;
    end
    else if (l_q.scl_p && !l_q.scl_s)
    begin
      if (l_q.strap_wait)
      begin
        l_d.strap_wait = 1'b0;
        if (!l_q.s0)
          l_d.strap_code = STRAP_GND;
        else if (!l_q.s1)
          l_d.strap_code = STRAP_SDA;
        else if (l_q.strap_s)
          l_d.strap_code = STRAP_VDD;
        else
          l_d.strap_code = STRAP_SCL;
      end
      case (l_q.st)
        BUS_ADDR:
        begin
          if (l_q.bits == BITS_BYTE)
          begin
            if (l_q.sh[7:1] == {ADDR_BASE, l_q.strap_code})
            begin
              l_d.st = BUS_ADDR_ACK;
              l_d.oe = 1'b1;
              l_d.rw = l_q.sh[0];
              l_d.rd_word = l_q.result;
            end
            else
              l_d.st = BUS_IDLE;
          end
        end
        BUS_ADDR_ACK:
        begin
          l_d.bits = '0;
          if (l_q.rw)
          begin
            l_d.st = BUS_RD;
            l_d.lo_byte = 1'b0;
            l_d.sh = l_q.rd_word[15:8];
            l_d.oe = ~l_q.rd_word[15];
          end
          else
          begin
            l_d.st = BUS_WR;
            l_d.oe = 1'b0;
          end
        end
        BUS_WR:
        begin
          if (l_q.bits == BITS_BYTE)
          begin
            l_d.st = BUS_WR_ACK;
            l_d.oe = 1'b1;
          end
        end
        BUS_WR_ACK:
        begin
          l_d.st = BUS_WR;
          l_d.bits = '0;
          l_d.oe = 1'b0;
        end
        BUS_RD:
        begin
          l_d.bits = l_q.bits + 4'h1;
          if (l_q.bits == BITS_LAST)
          begin
            l_d.st = BUS_RD_ACK;
            l_d.oe = 1'b0;
          end
          else
          begin
            l_d.sh = {l_q.sh[6:0], 1'b0};
            l_d.oe = ~l_q.sh[6];
          end
        end
        BUS_RD_ACK:
        begin
          if (l_q.nack)
            l_d.st = BUS_IDLE;
          else
          begin
            l_d.st = BUS_RD;
            l_d.bits = '0;
            l_d.lo_byte = ~l_q.lo_byte;
            l_d.sh = l_q.lo_byte ? l_q.rd_word[15:8] : l_q.rd_word[7:0];
            l_d.oe = l_q.lo_byte ? ~l_q.rd_word[15] : ~l_q.rd_word[7];
          end
        end
        default: l_d.oe = 1'b0;
      endcase
    end
    if (l_q.to_s)
    begin
      l_d.st = BUS_IDLE;
      l_d.oe = 1'b0;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst_s)
      l_q <= '0;
    else
      l_q <= l_d;
  end

  // ---------------------------------------------------------------
  // Outputs; both open-drain pins only ever pull low
  // ---------------------------------------------------------------
  assign sda_out = 1'b0;
  assign sda_oe = l_q.oe;
  assign alert_out = 1'b0;
  assign alert_oe = c_q.alert_oe;
  assign status.result = c_q.res;
  assign status.result_valid = c_q.res_valid;
  assign status.busy = (c_q.st != SEQ_SHUT);
  assign status.mode_state = (c_q.st == SEQ_SHUT) ? MODE_SHUTDOWN :
    (c_q.single ? MODE_SINGLE : MODE_CONT);

endmodule : ambient_light_measure_ctrl

`default_nettype wire

// File: src/ambient_light_pkg.sv
// Shared constants, types and timing figures of the light measurement block
package ambient_light_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int INTEG_SHORT_MS = 100;
  localparam int INTEG_LONG_MS = 800;
  localparam int ASSESS_MS = 10;
  localparam int OVERHEAD_MS = 3;
  localparam int BUS_TIMEOUT_MS = 28;
  localparam int CNT_W = 28;
  localparam int TO_W = 24;

  // ---------------------------------------------------------------
  // Field codes
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  localparam logic [3:0] RANGE_AUTO = 4'hc;
  localparam int EXP_TOP = 11;
  localparam logic [3:0] EXP_MAX = 4'hb;
  localparam int RAW_W = 23;
  localparam int MANT_W = 12;
  localparam logic [11:0] MANT_MAX = 12'hfff;
  localparam int LUX_W = 27;

  // ---------------------------------------------------------------
  // Serial bus address and strap codes
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_BASE = 5'h11;
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_VDD = 2'h1;
  localparam logic [1:0] STRAP_SDA = 2'h2;
  localparam logic [1:0] STRAP_SCL = 2'h3;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_LAST = 4'h7;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SEQ_SHUT, SEQ_ASSESS, SEQ_INTEG, SEQ_FINISH}
    seq_st_t;

  typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_WR,
    BUS_WR_ACK, BUS_RD, BUS_RD_ACK} bus_st_t;

  typedef struct packed {
    logic [1:0] conv_mode;
    logic integration_length_bit;
    logic [3:0] full_scale_range_field;
    logic alert_sense_invert;
    logic [15:0] low_limit;
    logic [15:0] high_limit;
  } cfg_t;

  typedef struct packed {
    logic [15:0] result;
    logic result_valid;
    logic busy;
    logic [1:0] mode_state;
  } status_t;

endpackage : ambient_light_pkg

// File: src/lux_scale.sv
// Scaling of a raw light sample into exponent and mantissa form
`timescale 1ns/100ps
`default_nettype none

module lux_scale
(
  input wire logic [ambient_light_pkg::RAW_W-1:0] raw,
  input wire logic [3:0] exp_sel,
  output logic [15:0] result,
  output logic [3:0] best_exp
);
  import ambient_light_pkg::*;

  logic [RAW_W-1:0] shifted;
  logic [11:0] mant;

  // Saturating mantissa at the chosen range; smallest range that fits
  always_comb
  begin
    shifted = raw >> exp_sel;
    if (shifted > RAW_W'(MANT_MAX))
      mant = MANT_MAX;
    else
      mant = shifted[MANT_W-1:0];
    result = {exp_sel, mant};
    best_exp = EXP_MAX;
    for (int e = EXP_TOP; e >= 0; e--)
    begin
      if ((raw >> e) <= RAW_W'(MANT_MAX))
        best_exp = 4'(e);
    end
  end

endmodule : lux_scale

`default_nettype wire

// File: test/amb_light_assertions.sv
// Port checks of the light measurement block
`timescale 1ns/100ps
`default_nettype none
module amb_checker
  import ambient_light_pkg::*;
#(
  parameter int INTEG_SHORT_CYC = 400,
  parameter int INTEG_LONG_CYC = 800,
  parameter int ASSESS_CYC = 40,
  parameter int OVERHEAD_CYC = 12,
  parameter int TIMEOUT_CYC = 300
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire ambient_light_pkg::cfg_t cfg,
  input wire ambient_light_pkg::status_t status,
  input wire logic alert_out,
  input wire logic alert_oe
);
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  logic [15:0] busy_q;
  logic [15:0] low_q;
  logic long_q;
  logic auto_q;
  int want_cyc;
  // Busy span, clock-low span; length kept from the start edge
  always_ff @(posedge clk)
  begin
    busy_q <= status.busy ? busy_q + 16'h1 : 16'h0;
    low_q <= (scl_in || sys_rst) ? 16'h0 : low_q + 16'h1;
    if ($rose(status.busy))
    begin
      long_q <= $past(cfg.integration_length_bit);
      auto_q <= $past(cfg.full_scale_range_field) == RANGE_AUTO;
    end
  end
  // Busy edges: integration, overhead and any range assessment
  assign want_cyc = (long_q ? INTEG_LONG_CYC : INTEG_SHORT_CYC)
    + OVERHEAD_CYC + (auto_q ? ASSESS_CYC : 0);

  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence single_go;
    !status.busy && cfg.conv_mode == MODE_SINGLE
      && $past(cfg.conv_mode) != MODE_SINGLE;
  endsequence
  sequence single_end;
    $fell(status.busy) && $past(status.mode_state) == MODE_SINGLE
      && $past(cfg.conv_mode) != MODE_SHUTDOWN;
  endsequence

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  // shutdown code stops
  a_shutdown_stops:
    assert property (cfg.conv_mode == MODE_SHUTDOWN |=> !status.busy)
    else $error("busy after shutdown code");
  a_single_start:
    assert property (single_go |=> status.mode_state == MODE_SINGLE)
    else $error("single shot did not start");
  a_cont_start:
    assert property (!status.busy && cfg.conv_mode[1]
      |=> status.mode_state == MODE_CONT) else $error("no continuous run");
  a_conv_time:
    assert property (single_end |-> busy_q == want_cyc[15:0])
    else $error("conversion length wrong");
  a_single_done:
    assert property (single_end |-> status.result_valid
      && status.mode_state == MODE_SHUTDOWN) else $error("bad single end");
  a_abort_keeps:
    assert property ($fell(status.busy) && $past(cfg.conv_mode)
      == MODE_SHUTDOWN |-> $stable(status.result)) else $error("abort result");
  a_open_drain:
    assert property (sda_out == 1'b0 && alert_out == 1'b0)
    else $error("open-drain pin driven high");
  a_alert_sense:
    assert property (!status.busy && $changed(cfg.alert_sense_invert)
      |=> $changed(alert_oe)) else $error("alert sense not inverted");
  a_bus_timeout:
    assert property (low_q > TIMEOUT_CYC + 80 |-> !sda_oe)
    else $error("data line held after timeout");
endmodule : amb_checker

bind ambient_light_measure_ctrl amb_checker #(
  .INTEG_SHORT_CYC(INTEG_SHORT_CYC), .INTEG_LONG_CYC(INTEG_LONG_CYC),
  .ASSESS_CYC(ASSESS_CYC), .OVERHEAD_CYC(OVERHEAD_CYC),
  .TIMEOUT_CYC(TIMEOUT_CYC)
) chk (.clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .cfg(cfg), .status(status), .alert_out(alert_out),
  .alert_oe(alert_oe));
`default_nettype wire

// File: test/i2c_host_model.sv
// Serial bus controller model; the clock stands high between frames
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model
(
  input wire logic link_clk,
  input wire logic sda_bus,
  output logic scl_drv,
  output logic sda_drv
);
  // Lines released at power-up
  initial
  begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // Data moves a tick after a clock fall, so no false start or stop
  task automatic tick(input int n);
    repeat (n * 6) @(posedge link_clk);
  endtask : tick
  task automatic bit_io(input logic b, output logic s);
    sda_drv <= b;
    tick(1);
    scl_drv <= 1'b1;
    tick(1);
    s = sda_bus;
    scl_drv <= 1'b0;
    tick(1);
  endtask : bit_io
  // start, then address and read bit
  task automatic send_addr(input logic [6:0] a, output logic ack);
    logic [7:0] ab;
    logic s;
    ab = {a, 1'b1};
    sda_drv <= 1'b0;
    tick(1);
    scl_drv <= 1'b0;
    tick(1);
    for (int i = 7; i >= 0; i--)
      bit_io(ab[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : send_addr
  task automatic stop;
    sda_drv <= 1'b0;
    tick(1);
    scl_drv <= 1'b1;
    tick(1);
    sda_drv <= 1'b1;
    tick(1);
  endtask : stop
  // Two result bytes; the last one is refused to end the read
  task automatic read_word(input logic [6:0] a, output logic ack,
    output logic [15:0] w);
    logic s;
    w = 16'h0;
    send_addr(a, ack);
    for (int i = 15; i >= 0 && ack; i--)
    begin
      bit_io(1'b1, w[i]);
      if (i[2:0] == 3'h0)
        bit_io(i != 8, s);
    end
    stop();
  endtask : read_word
  // clock held low across the acknowledge slot
  task automatic stall(input logic [6:0] a, output logic early,
    output logic late);
    logic [7:0] ab;
    logic s;
    ab = {a, 1'b1};
    sda_drv <= 1'b0;
    tick(1);
    scl_drv <= 1'b0;
    tick(1);
    for (int i = 7; i >= 0; i--)
      bit_io(ab[i], s);
    early = sda_bus;
    tick(10);
    late = sda_bus;
    stop();
  endtask : stall
endmodule : i2c_host_model
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench of the light measurement block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ambient_light_pkg::*;
  localparam int T_S = 400;
  localparam int T_L = 800;
  localparam int T_A = 40;
  localparam int T_O = 12;
  localparam logic [3:0] RNG [4] = '{4'h2, 4'h0, 4'hf, 4'hc};
  localparam logic [22:0] RAWV [4] = '{23'h1234, 23'h0abc, 23'h7fffff,
    23'h12345};
  localparam logic [22:0] WIN [3] = '{23'h40, 23'h4, 23'h800};
  logic clk, link_clk, sys_rst, scl, sda_drv, sda_oe, sda_bus, strap;
  logic alert_oe, ack, e1, e2;
  logic [1:0] strap_sel;
  logic [15:0] w;
  logic [RAW_W-1:0] raw;
  cfg_t cfg;
  status_t status;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;

  // Pull-up wire and strap wiring
  assign sda_bus = sda_drv & !sda_oe;
  assign strap = strap_sel[1] ? (strap_sel[0] ? scl : sda_bus)
    : strap_sel[0];

  ambient_light_measure_ctrl #(.INTEG_SHORT_CYC(T_S),
    .INTEG_LONG_CYC(T_L), .ASSESS_CYC(T_A), .OVERHEAD_CYC(T_O),
    .TIMEOUT_CYC(300)) dut (.clk(clk), .sys_rst(sys_rst),
    .link_clk(link_clk), .scl_in(scl), .sda_in(sda_bus), .sda_out(),
    .sda_oe(sda_oe), .addr_strap(strap), .raw_light(raw), .cfg(cfg),
    .status(status), .alert_out(), .alert_oe(alert_oe));
  i2c_host_model host (.link_clk(link_clk), .sda_bus(sda_bus),
    .scl_drv(scl), .sda_drv(sda_drv));

  // Clocks, the link one offset in phase
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize;
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  function automatic logic [15:0] scale(input logic [22:0] r,
    input logic [3:0] e);
    logic [22:0] m;
    m = r >> e;
    return {e, (m > 23'hfff) ? 12'hfff : m[11:0]};
  endfunction : scale
  // One single shot; n counts falling edges until busy drops
  task automatic single(input logic lng, input logic [3:0] rng,
    input logic [22:0] r);
    @(posedge clk);
    cfg.integration_length_bit <= lng;
    cfg.full_scale_range_field <= rng;
    cfg.conv_mode <= MODE_SINGLE;
    raw <= r;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while ((status.busy !== 1'b0 || n < 3) && n < 2000);
    @(posedge clk);
    cfg.conv_mode <= MODE_SHUTDOWN;
  endtask : single
  task automatic wait_res(input logic [15:0] want);
    n = 0;
    while (status.result !== want && n < 1000)
    begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
    check(status.result, want);
  endtask : wait_res

  // Main sequence; the design stretches reset for its link side
  initial
  begin
    sys_rst = 1'b1;
    cfg = '0;
    raw = '0;
    strap_sel = 2'h0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2000) @(negedge clk);
    check(status, 32'h0);
    check({sda_oe, alert_oe}, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      single(i == 1, RNG[i], RAWV[i]);
      check(n, (i == 1 ? T_L : T_S) + T_O + (i == 3 ? T_A : 0) + 2);
      check({status.result_valid, status.mode_state}, 32'h4);
      // Auto range: smallest exponent that does not saturate
      check(status.result, scale(RAWV[i], i == 3 ? 4'h5 : i == 2 ? EXP_MAX
        : RNG[i]));
    end
    // Window: inside, below, above in continuous mode
    @(posedge clk);
    cfg.low_limit <= 16'h0010;
    cfg.high_limit <= 16'h0100;
    cfg.full_scale_range_field <= 4'h2;
    cfg.conv_mode <= MODE_CONT;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      raw <= WIN[i];
      wait_res(scale(WIN[i], 4'h2));
      check(alert_oe, i != 0);
    end
    check(status.mode_state, MODE_CONT);
    // Abort mid integration keeps the last result
    repeat (100) @(posedge clk);
    raw <= 23'h7;
    cfg.conv_mode <= MODE_SHUTDOWN;
    repeat (3) @(negedge clk);
    check({status.busy, status.result}, {1'b0, scale(WIN[2], 4'h2)});
    @(posedge clk);
    cfg.alert_sense_invert <= 1'b1;
    repeat (3) @(negedge clk);
    check(alert_oe, 1'b0);
    for (int s = 0; s < 4; s++)
    begin
      // Strap settles well before the start condition is sent
      @(posedge clk);
      strap_sel <= s[1:0];
      repeat (100) @(posedge clk);
      host.read_word({ADDR_BASE, s[1:0]}, ack, w);
      check({ack, w}, {1'b1, scale(WIN[2], 4'h2)});
    end
    host.read_word({ADDR_BASE, 2'h0}, ack, w);
    check(ack, 1'b0);
    host.stall({ADDR_BASE, 2'h3}, e1, e2);
    check({e1, e2}, 32'h1);
    host.read_word({ADDR_BASE, 2'h3}, ack, w);
    check({ack, w}, {1'b1, scale(WIN[2], 4'h2)});
    summarize();
  end
endmodule : tb_top
`default_nettype wire
